// [pkg/amtc_pkg.sv]
// Package for the converter mode, trigger and channel control block.
// Assumes a plain register port with byte addresses and 32-bit data.
package amtc_pkg;
    // Register byte offsets
    localparam logic [7:0] MODE_ONE_OFS = 8'h00;
    localparam logic [7:0] CHAN_SEL_OFS = 8'h04;
    // Mode register field positions
    localparam int REF_ON_BIT = 7;
    localparam int IDLE_RUN_BIT = 6;
    localparam int LADDER_ALWAYS_BIT = 5;
    localparam int PRI_SRC_BIT = 3;
    localparam int PRI_HWEN_BIT = 2;
    localparam int NRM_SRC_BIT = 1;
    localparam int NRM_HWEN_BIT = 0;
    localparam logic [7:0] MODE_ONE_MASK = 8'hef;
    // Channel register field positions and layout
    localparam int PRI_CH_LSB = 4;
    localparam int NRM_CH_LSB = 0;
    localparam int CH_W = 4;
    localparam int NUM_INPUTS = 12;
    localparam logic [3:0] CH_LIMIT = 4'hb;
    // Reset values
    localparam logic [7:0] MODE_ONE_RST = 8'h00;
    localparam logic [7:0] CHAN_SEL_RST = 8'h00;
    // Reference settling time and its cycle count at 100 MHz
    localparam int REF_SETTLE_NS = 3000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int REF_SETTLE_CYC = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Trigger source codes
    typedef enum logic [1:0] {
        AMTC_SRC_NONE = 2'b00,
        AMTC_SRC_EXT = 2'b01,
        AMTC_SRC_CAP = 2'b10
    } amtc_src_t;
endpackage : amtc_pkg

// [src/amtc_sync3.sv]
// Three-stage synchroniser for one pin input.
// Assumes the input is asynchronous to ref_clk.
`timescale 1ns/1ps
module amtc_sync3 (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Pin in, settled level out
    input wire logic pinIn,
    output logic levelOut
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
    logic level_nxt;

    // A change counts only once the second and third stages agree
    always_comb begin
        level_nxt = level_r;
        if (s2_r == s3_r) begin
            level_nxt = s3_r;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign levelOut = level_r;
endmodule : amtc_sync3

// [src/amtc_ctrl.sv]
// Mode, hardware trigger and channel control for the analog converter.
// Assumes capture events are one-cycle pulses on ref_clk and the external
// trigger is an asynchronous pin.
//
// Overview of operation
// - Mode bit 7 turns the reference voltage on when set; resets to zero.
// - Mode bit 6 keeps the converter running in idle when set.
// - Mode bit 5 drives ladder current always, else only while converting.
// - Mode bit 3 picks priority hardware source: external trigger or capture one.
// - Mode bit 2 enables hardware starts of the priority conversion.
// - Mode bit 1 picks normal hardware source: external trigger or capture two.
// - Mode bit 0 enables hardware starts of the normal conversion.
// - External trigger used for priority starts never starts normal conversion.
// - Channel bits 7..4 pick the priority input; codes 1100 up forbidden.
// - Channel bits 3..0 pick the normal input; codes 1100 up forbidden.
// - Both armed on one external trigger: only priority conversion starts.
`timescale 1ns/1ps
module amtc_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // Software start strobes from the start register
    input wire logic normalSoftStart,
    input wire logic prioritySoftStart,
    // Trigger sources
    input wire logic extTriggerPin,
    input wire logic captureEventFirst,
    input wire logic captureEventSecond,
    // Converter core status and power state
    input wire logic converting,
    input wire logic idleMode,
    // Converter core controls
    output logic referenceOn,
    output logic ladderCurrentOn,
    output logic converterRun,
    output logic normalStart,
    output logic priorityStart,
    output logic [11:0] normalInputSel,
    output logic [11:0] priorityInputSel,
    output logic refSettled
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] modeOne_r;
    logic [7:0] modeOne_nxt;
    logic [7:0] chanSel_r;
    logic [7:0] chanSel_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // Forbidden codes are kept out so the decoders never see them
    function automatic logic [3:0] amtc_ch_clip(input logic [3:0] req, input logic [3:0] cur);
        amtc_ch_clip = (req > amtc_pkg::CH_LIMIT) ? cur : req;
    endfunction : amtc_ch_clip

    function automatic logic [11:0] amtc_ch_decode(input logic [3:0] code);
        amtc_ch_decode = 12'h000;
        if (code <= amtc_pkg::CH_LIMIT) begin
            amtc_ch_decode = 12'h001 << code;
        end
    endfunction : amtc_ch_decode

    always_comb begin
        modeOne_nxt = modeOne_r;
        chanSel_nxt = chanSel_r;
        rdata_nxt = 32'h0000_0000;
        if (regWrite && regAddr == amtc_pkg::MODE_ONE_OFS) begin
            modeOne_nxt = regWdata[7:0] & amtc_pkg::MODE_ONE_MASK;
        end
        if (regWrite && regAddr == amtc_pkg::CHAN_SEL_OFS) begin
            chanSel_nxt[7:4] = amtc_ch_clip(regWdata[7:4], chanSel_r[7:4]);
            chanSel_nxt[3:0] = amtc_ch_clip(regWdata[3:0], chanSel_r[3:0]);
        end
        if (regRead) begin
            case (regAddr)
                amtc_pkg::MODE_ONE_OFS: rdata_nxt = {24'h000000, modeOne_r};
                amtc_pkg::CHAN_SEL_OFS: rdata_nxt = {24'h000000, chanSel_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            modeOne_r <= amtc_pkg::MODE_ONE_RST;
            chanSel_r <= amtc_pkg::CHAN_SEL_RST;
            rdata_r <= 32'h0000_0000;
        end else begin
            modeOne_r <= modeOne_nxt;
            chanSel_r <= chanSel_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign regRdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Field views

    logic refOnBit;
    logic idleRunBit;
    logic ladderAlwaysBit;
    logic priSrcBit;
    logic priHwEnBit;
    logic nrmSrcBit;
    logic nrmHwEnBit;

    assign refOnBit = modeOne_r[amtc_pkg::REF_ON_BIT];
    assign idleRunBit = modeOne_r[amtc_pkg::IDLE_RUN_BIT];
    assign ladderAlwaysBit = modeOne_r[amtc_pkg::LADDER_ALWAYS_BIT];
    assign priSrcBit = modeOne_r[amtc_pkg::PRI_SRC_BIT];
    assign priHwEnBit = modeOne_r[amtc_pkg::PRI_HWEN_BIT];
    assign nrmSrcBit = modeOne_r[amtc_pkg::NRM_SRC_BIT];
    assign nrmHwEnBit = modeOne_r[amtc_pkg::NRM_HWEN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // External trigger: synchronise, then take the rising edge

    logic extLevel;
    logic extPrev_r;
    logic extPrev_nxt;
    logic extRise;

    amtc_sync3 amtc_sync3_inst (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pinIn(extTriggerPin),
        .levelOut(extLevel)
    );

    always_comb begin
        extPrev_nxt = extLevel;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            extPrev_r <= 1'b0;
        end else begin
            extPrev_r <= extPrev_nxt;
        end
    end

    assign extRise = extLevel & ~extPrev_r;

    ////////////////////////////////////////////////////////////////////////
    // Hardware start selection and priority

    amtc_pkg::amtc_src_t priSrc;
    amtc_pkg::amtc_src_t nrmSrc;
    logic priHwStart;
    logic nrmHwStart;
    logic priStart_r;
    logic priStart_nxt;
    logic nrmStart_r;
    logic nrmStart_nxt;

    always_comb begin
        priSrc = amtc_pkg::AMTC_SRC_NONE;
        nrmSrc = amtc_pkg::AMTC_SRC_NONE;
        if (priHwEnBit) begin
            priSrc = priSrcBit ? amtc_pkg::AMTC_SRC_CAP : amtc_pkg::AMTC_SRC_EXT;
        end
        if (nrmHwEnBit) begin
            nrmSrc = nrmSrcBit ? amtc_pkg::AMTC_SRC_CAP : amtc_pkg::AMTC_SRC_EXT;
        end
        // External trigger owned by the priority path is withheld from normal
        if (priSrc == amtc_pkg::AMTC_SRC_EXT && nrmSrc == amtc_pkg::AMTC_SRC_EXT) begin
            nrmSrc = amtc_pkg::AMTC_SRC_NONE;
        end
    end

    always_comb begin
        case (priSrc)
            amtc_pkg::AMTC_SRC_EXT: priHwStart = extRise;
            amtc_pkg::AMTC_SRC_CAP: priHwStart = captureEventFirst;
            default: priHwStart = 1'b0;
        endcase
        case (nrmSrc)
            amtc_pkg::AMTC_SRC_EXT: nrmHwStart = extRise;
            amtc_pkg::AMTC_SRC_CAP: nrmHwStart = captureEventSecond;
            default: nrmHwStart = 1'b0;
        endcase
    end

    // Starts are gated by the reference enable; a start with the
    // reference off would convert against an absent reference
    always_comb begin
        priStart_nxt = refOnBit & (priHwStart | prioritySoftStart);
        nrmStart_nxt = refOnBit & (nrmHwStart | normalSoftStart);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            priStart_r <= 1'b0;
            nrmStart_r <= 1'b0;
        end else begin
            priStart_r <= priStart_nxt;
            nrmStart_r <= nrmStart_nxt;
        end
    end

    assign priorityStart = priStart_r;
    assign normalStart = nrmStart_r;

    ////////////////////////////////////////////////////////////////////////
    // Reference settling counter (status only, software keeps the wait)

    logic [15:0] settleCnt_r;
    logic [15:0] settleCnt_nxt;

    always_comb begin
        settleCnt_nxt = settleCnt_r;
        if (!refOnBit) begin
            settleCnt_nxt = 16'h0000;
        end else if (settleCnt_r != 16'(amtc_pkg::REF_SETTLE_CYC)) begin
            settleCnt_nxt = settleCnt_r + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            settleCnt_r <= 16'h0000;
        end else begin
            settleCnt_r <= settleCnt_nxt;
        end
    end

    assign refSettled = (settleCnt_r == 16'(amtc_pkg::REF_SETTLE_CYC));

    ////////////////////////////////////////////////////////////////////////
    // Analog controls, registered so the core sees clean levels

    logic refOn_r;
    logic ladder_r;
    logic run_r;
    logic [11:0] nrmSel_r;
    logic [11:0] priSel_r;
    logic refOn_nxt;
    logic ladder_nxt;
    logic run_nxt;
    logic [11:0] nrmSel_nxt;
    logic [11:0] priSel_nxt;

    always_comb begin
        refOn_nxt = refOnBit;
        ladder_nxt = ladderAlwaysBit | converting;
        run_nxt = ~idleMode | idleRunBit;
        nrmSel_nxt = amtc_ch_decode(chanSel_r[amtc_pkg::NRM_CH_LSB +: amtc_pkg::CH_W]);
        priSel_nxt = amtc_ch_decode(chanSel_r[amtc_pkg::PRI_CH_LSB +: amtc_pkg::CH_W]);
    end

    // Reset clears the ladder bit, so current stops while reset is held
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            refOn_r <= 1'b0;
            ladder_r <= 1'b0;
            run_r <= 1'b1;
            nrmSel_r <= 12'h001;
            priSel_r <= 12'h001;
        end else begin
            refOn_r <= refOn_nxt;
            ladder_r <= ladder_nxt;
            run_r <= run_nxt;
            nrmSel_r <= nrmSel_nxt;
            priSel_r <= priSel_nxt;
        end
    end

    assign referenceOn = refOn_r;
    assign ladderCurrentOn = ladder_r;
    assign converterRun = run_r;
    assign normalInputSel = nrmSel_r;
    assign priorityInputSel = priSel_r;

endmodule : amtc_ctrl

// [test/amtc_ctrl_sva.sv]
// Checker for the mode, trigger and channel control block.
// Sees only the top module's ports; bound from the bench top file.
`timescale 1ns/1ps
module amtc_ctrl_sva (
    // Clock, reset and register port
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    // Sources, core status and outputs
    input wire logic normalSoftStart,
    input wire logic captureEventFirst,
    input wire logic captureEventSecond,
    input wire logic converting,
    input wire logic idleMode,
    input wire logic referenceOn,
    input wire logic ladderCurrentOn,
    input wire logic converterRun,
    input wire logic normalStart,
    input wire logic priorityStart,
    input wire logic [11:0] normalInputSel
);
    logic [7:0] modeR;
    logic [3:0] chanR;
    // Shadow copies of the mode and normal channel fields so the checked outputs can be tied back to what software wrote
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            modeR <= 8'h00;
            chanR <= 4'h0;
        end else if (regWrite && regAddr == amtc_pkg::MODE_ONE_OFS) begin
            modeR <= regWdata[7:0] & amtc_pkg::MODE_ONE_MASK;
        end else if (regWrite && regAddr == amtc_pkg::CHAN_SEL_OFS) begin
            if (regWdata[3:0] <= amtc_pkg::CH_LIMIT) chanR <= regWdata[3:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence sModeRead;
        regRead && regAddr == amtc_pkg::MODE_ONE_OFS;
    endsequence
    sequence sPriCap;
        captureEventFirst && modeR[7] && modeR[3] && modeR[2];
    endsequence
    sequence sNrmCap;
        captureEventSecond && modeR[7] && modeR[1] && modeR[0];
    endsequence
    // Mode held steady so no edge armed under an older setting is in flight
    sequence sExtShared;
        $past(modeR, 6) == modeR && modeR[2] && !modeR[3] && !modeR[1]
            && !$past(normalSoftStart);
    endsequence
    AST_RD_MODE: assert property (sModeRead |=> regRdata == {24'h0, modeR})
        else $error("mode readback wrong");
    AST_RD_IDLE: assert property (!regRead |=> regRdata == 32'h0)
        else $error("read data outside read slot");
    AST_REF_ON: assert property (referenceOn == $past(modeR[7]))
        else $error("reference enable wrong");
    AST_LADDER: assert property (ladderCurrentOn == $past(modeR[5] | converting))
        else $error("ladder current wrong");
    AST_RUN: assert property (converterRun == $past(!idleMode | modeR[6]))
        else $error("idle run wrong");
    AST_PRI_CAP: assert property (sPriCap |=> priorityStart)
        else $error("priority capture start missing");
    AST_NRM_CAP: assert property (sNrmCap |=> normalStart)
        else $error("normal capture start missing");
    AST_EXT_PRI_ONLY: assert property (sExtShared |-> !normalStart)
        else $error("normal start on shared trigger");
    AST_NRM_CH: assert property (normalInputSel == 12'h001 << $past(chanR))
        else $error("normal input select wrong");
endmodule : amtc_ctrl_sva

// [test/amtc_core_model.sv]
// Behavioural converter core: answers each start with a busy spell.
// Assumes start pulses are one cycle long on ref_clk.
`timescale 1ns/1ps
module amtc_core_model #(
    parameter int CONV_CYC = 12
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Start pulses in, busy level out
    input wire logic normalStart,
    input wire logic priorityStart,
    output logic converting
);
    int countR;
    // A new start restarts the spell, as a priority start preempts
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) countR <= 0;
        else if (normalStart || priorityStart) countR <= CONV_CYC;
        else if (countR > 0) countR <= countR - 1;
    end
    assign converting = (countR > 0);
endmodule : amtc_core_model

// [test/amtc_ctrl_tb_top.sv]
// Bench top for the mode, trigger and channel control block.
// Drives the register port and trigger inputs; the core model answers starts.
`timescale 1ns/1ps
module amtc_ctrl_tb_top;
    localparam logic [7:0] MOD = amtc_pkg::MODE_ONE_OFS;
    localparam logic [7:0] CHN = amtc_pkg::CHAN_SEL_OFS;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0, regRead = 1'b0, idleMode = 1'b0, extTriggerPin = 1'b0;
    logic normalSoftStart = 1'b0, prioritySoftStart = 1'b0;
    logic captureEventFirst = 1'b0, captureEventSecond = 1'b0;
    logic converting, referenceOn, ladderCurrentOn, converterRun, refSettled;
    logic normalStart, priorityStart;
    logic [31:0] regRdata;
    logic [11:0] normalInputSel, priorityInputSel;
    int errTotal = 0;
    int checksDone = 0;
    always #5 ref_clk = ~ref_clk;
    amtc_ctrl amtc_ctrl_inst (
        .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .normalSoftStart(normalSoftStart), .prioritySoftStart(prioritySoftStart),
        .extTriggerPin(extTriggerPin), .captureEventFirst(captureEventFirst),
        .captureEventSecond(captureEventSecond), .converting(converting),
        .idleMode(idleMode), .referenceOn(referenceOn), .ladderCurrentOn(ladderCurrentOn),
        .converterRun(converterRun), .normalStart(normalStart),
        .priorityStart(priorityStart), .normalInputSel(normalInputSel),
        .priorityInputSel(priorityInputSel), .refSettled(refSettled)
    );
    amtc_core_model amtc_core_model_inst (
        .ref_clk(ref_clk), .resetn(resetn), .normalStart(normalStart),
        .priorityStart(priorityStart), .converting(converting)
    );
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 chk(regRdata, exp);
    endtask : rd
    // One source pulse, then the start outputs in the answer cycle
    task automatic hit(input int sel, input logic expPri, input logic expNrm);
        @(posedge ref_clk);
        case (sel)
            0: captureEventFirst <= 1'b1;
            1: captureEventSecond <= 1'b1;
            2: prioritySoftStart <= 1'b1;
            default: normalSoftStart <= 1'b1;
        endcase
        @(posedge ref_clk);
        {captureEventFirst, captureEventSecond, prioritySoftStart, normalSoftStart} <= 4'h0;
        #1 chk({priorityStart, normalStart}, {expPri, expNrm});
    endtask : hit
    task automatic ext_fire(input logic expPri, input logic expNrm);
        logic seenP = 1'b0;
        logic seenN = 1'b0;
        @(posedge ref_clk);
        extTriggerPin <= 1'b1;
        repeat (10) begin
            @(posedge ref_clk);
            #1 seenP |= priorityStart;
            seenN |= normalStart;
        end
        @(posedge ref_clk);
        extTriggerPin <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk({seenP, seenN}, {expPri, expNrm});
    endtask : ext_fire
    // Reference on, then wait for it to settle before arming triggers
    task automatic arm(input logic [31:0] m);
        int n = 0;
        wr(MOD, 32'h80);
        // Sampled after the edge so the count is not racing its own update
        while (refSettled !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(32'(n), 32'(amtc_pkg::REF_SETTLE_CYC));
        wr(MOD, m);
    endtask : arm
    ////////////////////////////////////////////////////////////////
    task automatic t_mode;
        rd(MOD, 32'h0);
        rd(8'h08, 32'h0);
        wr(MOD, 32'hffffffff);
        rd(MOD, 32'h000000ef);
        chk({referenceOn, ladderCurrentOn, converterRun}, 3'b111);
        wr(MOD, 32'h0);
        @(posedge ref_clk);
        idleMode <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 chk({referenceOn, ladderCurrentOn, converterRun}, 3'b000);
        wr(MOD, 32'h40);
        repeat (2) @(posedge ref_clk);
        #1 chk(converterRun, 1'b1);
        @(posedge ref_clk);
        idleMode <= 1'b0;
    endtask : t_mode
    task automatic t_chan;
        for (int c = 0; c < 12; c++) begin
            wr(CHN, {24'h0, 4'(c), 4'(11 - c)});
            @(posedge ref_clk);
            #1 chk({priorityInputSel, normalInputSel}, {12'h001 << c, 12'h001 << (11 - c)});
        end
        wr(CHN, 32'hffffffcc);
        rd(CHN, 32'h000000b0);
        wr(CHN, 32'h000000c5);
        rd(CHN, 32'h000000b5);
    endtask : t_chan
    task automatic t_starts;
        arm(32'h8e);
        hit(0, 1'b1, 1'b0);
        hit(1, 1'b0, 1'b0);
        hit(2, 1'b1, 1'b0);
        hit(3, 1'b0, 1'b1);
        wr(MOD, 32'h8b);
        hit(0, 1'b0, 1'b0);
        hit(1, 1'b0, 1'b1);
        wr(MOD, 32'h86);
        hit(0, 1'b0, 1'b0);
        wr(MOD, 32'h89);
        hit(1, 1'b0, 1'b0);
        wr(MOD, 32'h0f);
        hit(0, 1'b0, 1'b0);
    endtask : t_starts
    task automatic t_ext;
        arm(32'h85);
        ext_fire(1'b1, 1'b0);
        wr(MOD, 32'h81);
        ext_fire(1'b0, 1'b1);
        wr(MOD, 32'h0);
    endtask : t_ext
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        t_mode();
        t_chan();
        t_starts();
        t_ext();
        finish_test();
    end
    initial begin
        #100us;
        errTotal++;
        finish_test();
    end
endmodule : amtc_ctrl_tb_top
bind amtc_ctrl amtc_ctrl_sva amtc_ctrl_sva_inst (
    .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .normalSoftStart(normalSoftStart), .captureEventFirst(captureEventFirst),
    .captureEventSecond(captureEventSecond), .converting(converting), .idleMode(idleMode),
    .referenceOn(referenceOn), .ladderCurrentOn(ladderCurrentOn),
    .converterRun(converterRun), .normalStart(normalStart), .priorityStart(priorityStart),
    .normalInputSel(normalInputSel)
);
